// ---- rtl/ctt_unit.sv ----
`timescale 1ns/100ps
`include "ctt_cfg.svh"
module ctt_unit
   import ctt_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction at execute
   input wire ctt_instr_t instr,
   output logic instr_ready,
   // Operands from the register file
   input wire logic [`CTT_XLEN-1:0] first_source,
   input wire logic [`CTT_XLEN-1:0] second_source,
   // Condition codes
   input wire ctt_icc_t icc,
   input wire logic [1:0] fcc,
   input wire logic [1:0] ccc,
   // Configuration
   input wire logic [`CTT_NWIN-1:0] invalid_window_mask,
   input wire logic [`CTT_TBR_BASE_W-1:0] trap_base_addr,
   // Program counters
   output logic [`CTT_XLEN-1:0] pc,
   output logic [`CTT_XLEN-1:0] next_pc,
   // Processor state
   output logic [`CTT_WP_W-1:0] window_pointer,
   output logic trap_enable_bit,
   output logic supervisor_bit,
   output logic prior_supervisor_bit,
   output logic [`CTT_XLEN-1:0] trap_base_reg,
   output logic error_mode,
   output logic annul_pending,
   // Register file writes
   output ctt_rf_wr_t wr_a,
   output ctt_rf_wr_t wr_b,
   // Events
   output logic trap_taken,
   output logic illegal_trap,
   output logic window_overflow,
   output logic window_underflow,
   output logic reset_trap
);

   // ----------------------------------------
   // Operand and target arithmetic
   // ----------------------------------------
   logic [`CTT_TBR_TT_W-1:0] trap_type_field;

   wire fire = instr.valid & ~error_mode;
   wire [`CTT_XLEN-1:0] imm_ext = {{19{instr.signed_immediate[12]}}, instr.signed_immediate};
   wire [`CTT_XLEN-1:0] operand2 = instr.imm_sel ? imm_ext : second_source; // RULE4 RULE17
   wire [`CTT_XLEN-1:0] src_sum = first_source + operand2;
   wire [`CTT_XLEN-1:0] disp22_ext = {{10{instr.disp[21]}}, instr.disp[21:0]};
   wire [`CTT_XLEN-1:0] branch_target = pc + `CTT_PC_STEP + disp22_ext; // RULE23
   wire [`CTT_XLEN-1:0] call_target = pc + {instr.disp, 2'b00}; // RULE16
   wire [`CTT_XLEN-1:0] seq_npc = next_pc + `CTT_PC_STEP; // RULE22
   wire [`CTT_TBR_TT_W-1:0] sw_trap_type = `CTT_SW_TRAP_OFFSET | {1'b0, src_sum[6:0]}; // RULE3 RULE4

   // ----------------------------------------
   // Condition evaluation
   // ----------------------------------------
   ctt_cc_class_t cc_class;
   logic cond_true;

   assign cc_class = (instr.op == OP_FLOAT_BRANCH) ? CC_FLOAT :
                     (instr.op == OP_COPROC_BRANCH) ? CC_COPROC : CC_INT;

   ctt_cond_eval u_cond (
      .cls(cc_class),
      .cond(instr.cond),
      .icc(icc),
      .fcc(fcc),
      .ccc(ccc),
      .cond_true(cond_true)
   );

   wire is_branch = (instr.op == OP_INT_BRANCH) | (instr.op == OP_FLOAT_BRANCH) |
                    (instr.op == OP_COPROC_BRANCH);
   wire branch_always = (instr.cond == `CTT_COND_ALWAYS);
   wire taken = is_branch & cond_true;
   // Taken conditional branches keep their slot even when annul is set
   wire annul_slot = is_branch & instr.annul & (~taken | branch_always); // RULE24

   // ----------------------------------------
   // Window pointer stepping
   // ----------------------------------------
   logic [`CTT_WP_W-1:0] wp_down;
   logic [`CTT_WP_W-1:0] wp_up;
   logic down_invalid;
   logic up_invalid;

   ctt_win_step u_win_down (
      .wp(window_pointer),
      .step_up(1'b0),
      .invalid_window_mask(invalid_window_mask),
      .new_wp(wp_down),
      .new_invalid(down_invalid)
   );

   ctt_win_step u_win_up (
      .wp(window_pointer),
      .step_up(1'b1),
      .invalid_window_mask(invalid_window_mask),
      .new_wp(wp_up),
      .new_invalid(up_invalid)
   );

   // Return checks are made against the already incremented window
   wire return_from_trap_bad = ~supervisor_bit | up_invalid | (src_sum[1:0] != 2'b00); // RULE6 RULE8

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [`CTT_XLEN-1:0] next_pc_reg;
   logic [`CTT_XLEN-1:0] next_next_pc;
   logic [`CTT_WP_W-1:0] next_window_pointer;
   logic next_trap_enable_bit;
   logic next_supervisor_bit;
   logic next_prior_supervisor_bit;
   logic [`CTT_TBR_TT_W-1:0] next_trap_type_field;
   logic next_error_mode;
   logic next_annul_pending;
   ctt_rf_wr_t next_wr_a;
   ctt_rf_wr_t next_wr_b;
   logic next_trap_taken;
   logic next_illegal_trap;
   logic next_window_overflow;
   logic next_window_underflow;
   logic next_reset_trap;
   logic enter_trap;
   logic [`CTT_TBR_TT_W-1:0] enter_type;
   logic [`CTT_XLEN-1:0] trap_pc;

   assign trap_pc = {trap_base_addr, enter_type, `CTT_TBR_ZERO};
   assign instr_ready = ~error_mode;

   // Classify the instruction: whether it traps and with which trap type
   always_comb begin
      enter_trap = 1'b0;
      enter_type = trap_type_field;
      next_illegal_trap = 1'b0;
      next_window_overflow = 1'b0;
      next_window_underflow = 1'b0;
      next_reset_trap = 1'b0;
      if (fire && !annul_pending) begin // RULE25
         unique case (instr.op)
            OP_COND_TRAP: begin
               if (cond_true) begin // RULE1 RULE2
                  enter_trap = 1'b1;
                  enter_type = sw_trap_type; // RULE3
               end
            end
            OP_SAVE_WIN: begin
               if (down_invalid) begin // RULE20
                  enter_trap = 1'b1;
                  enter_type = `CTT_TT_WIN_OVERFLOW;
                  next_window_overflow = 1'b1;
               end
            end
            OP_RESTORE_WIN: begin
               if (up_invalid) begin // RULE20
                  enter_trap = 1'b1;
                  enter_type = `CTT_TT_WIN_UNDERFLOW;
                  next_window_underflow = 1'b1;
               end
            end
            OP_RETURN_TRAP: begin
               if (trap_enable_bit) begin // RULE7
                  enter_trap = 1'b1;
                  enter_type = `CTT_TT_ILLEGAL;
                  next_illegal_trap = 1'b1;
               end else if (return_from_trap_bad) begin // RULE8
                  enter_type = `CTT_TT_RESET;
                  next_reset_trap = 1'b1;
               end
            end
            OP_OTHER, OP_INT_BRANCH, OP_FLOAT_BRANCH, OP_COPROC_BRANCH,
            OP_CALL, OP_JUMP_LINK: begin
               enter_trap = 1'b0;
            end
         endcase
      end
   end

   // Update the architectural state
   always_comb begin
      next_pc_reg = pc;
      next_next_pc = next_pc;
      next_window_pointer = window_pointer;
      next_trap_enable_bit = trap_enable_bit;
      next_supervisor_bit = supervisor_bit;
      next_prior_supervisor_bit = prior_supervisor_bit;
      next_trap_type_field = trap_type_field;
      next_error_mode = error_mode;
      next_annul_pending = annul_pending;
      next_wr_a = '0;
      next_wr_b = '0;
      next_trap_taken = 1'b0;
      if (fire) begin
         // Default ending: next-PC moves into PC, next-PC steps on
         next_pc_reg = next_pc; // RULE21 RULE22
         next_next_pc = seq_npc; // RULE22
         next_annul_pending = 1'b0;
         if (annul_pending) begin
            next_annul_pending = 1'b0; // RULE25
         end else if (enter_trap) begin
            next_trap_taken = 1'b1;
            next_trap_enable_bit = 1'b0; // RULE5
            next_prior_supervisor_bit = supervisor_bit; // RULE5
            next_window_pointer = wp_down; // RULE5
            next_wr_a = '{we: 1'b1, win: wp_down, idx: `CTT_REG_TRAP_PC, data: pc}; // RULE5
            next_wr_b = '{we: 1'b1, win: wp_down, idx: `CTT_REG_TRAP_NPC, data: next_pc};
            next_supervisor_bit = 1'b1; // RULE5
            next_trap_type_field = enter_type; // RULE3
            // Trap entry is not delayed: the slot never runs
            next_pc_reg = trap_pc; // RULE1 RULE5
            next_next_pc = trap_pc + `CTT_PC_STEP; // RULE5
         end else if (next_reset_trap) begin
            // Processor stops; the architectural counters are frozen
            next_error_mode = 1'b1; // RULE8
            next_trap_type_field = enter_type;
            next_pc_reg = pc;
            next_next_pc = next_pc;
         end else begin
            unique case (instr.op)
               OP_INT_BRANCH, OP_FLOAT_BRANCH, OP_COPROC_BRANCH: begin
                  if (taken) begin
                     next_next_pc = branch_target; // RULE21 RULE23
                  end
                  next_annul_pending = annul_slot; // RULE24
               end
               OP_CALL: begin
                  next_wr_a = '{we: 1'b1, win: window_pointer,
                                idx: `CTT_REG_CALL_LINK, data: pc}; // RULE16
                  next_next_pc = call_target; // RULE16
               end
               OP_JUMP_LINK: begin
                  next_wr_a = '{we: 1'b1, win: window_pointer, idx: instr.rd, data: pc}; // RULE17
                  next_next_pc = src_sum; // RULE17
               end
               OP_SAVE_WIN: begin
                  next_window_pointer = wp_down; // RULE18
                  next_wr_a = '{we: 1'b1, win: wp_down, idx: instr.rd, data: src_sum}; // RULE18
               end
               OP_RESTORE_WIN: begin
                  next_window_pointer = wp_up; // RULE19
                  next_wr_a = '{we: 1'b1, win: wp_up, idx: instr.rd, data: src_sum}; // RULE19
               end
               OP_RETURN_TRAP: begin
                  next_window_pointer = wp_up; // RULE6
                  next_trap_enable_bit = 1'b1; // RULE9
                  next_supervisor_bit = prior_supervisor_bit; // RULE9
                  next_next_pc = src_sum; // RULE9
               end
               OP_COND_TRAP, OP_OTHER: begin
                  next_annul_pending = 1'b0; // RULE2
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= `CTT_RESET_PC;
         next_pc <= `CTT_RESET_NPC;
         window_pointer <= `CTT_RESET_WP;
         trap_enable_bit <= 1'b0;
         supervisor_bit <= 1'b1;
         prior_supervisor_bit <= 1'b1;
         trap_type_field <= '0;
         error_mode <= 1'b0;
         annul_pending <= 1'b0;
      end else begin
         pc <= next_pc_reg;
         next_pc <= next_next_pc;
         window_pointer <= next_window_pointer;
         trap_enable_bit <= next_trap_enable_bit;
         supervisor_bit <= next_supervisor_bit;
         prior_supervisor_bit <= next_prior_supervisor_bit;
         trap_type_field <= next_trap_type_field;
         error_mode <= next_error_mode;
         annul_pending <= next_annul_pending;
      end
   end

   // Output registers: writes, one-cycle events and the trap base register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_a <= '0;
         wr_b <= '0;
         trap_taken <= 1'b0;
         illegal_trap <= 1'b0;
         window_overflow <= 1'b0;
         window_underflow <= 1'b0;
         reset_trap <= 1'b0;
         trap_base_reg <= '0;
      end else begin
         wr_a <= next_wr_a;
         wr_b <= next_wr_b;
         trap_taken <= next_trap_taken;
         illegal_trap <= next_illegal_trap;
         window_overflow <= next_window_overflow;
         window_underflow <= next_window_underflow;
         reset_trap <= next_reset_trap;
         trap_base_reg <= {trap_base_addr, next_trap_type_field, `CTT_TBR_ZERO};
      end
   end

endmodule

// ---- rtl/ctt_cfg.svh ----
// What this block does
// RULE1: True conditional trap enters trap, no delay slot
// RULE2: False conditional trap acts as no-operation
// RULE3: Trap-type field gets trap number plus 128
// RULE4: Trap number is low seven bits of sum
// RULE5: Trap entry: disable, save state, load base
// RULE6: Return bumps window, forms address, then checks
// RULE7: Return with traps enabled raises illegal trap
// RULE8: Return errors cause reset trap, error mode
// RULE9: Clean return enables traps, restores supervisor bit
// RULE10: Integer codes 1000-1111 test listed conditions
// RULE11: Integer 0000 never, 0001 equal, others listed
// RULE12: Float codes 0000-0111 test listed relations
// RULE13: Float codes 1000-1111 test listed relations
// RULE14: Coprocessor codes 0000-0111 match listed values
// RULE15: Coprocessor codes 1000-1111 match listed values
// RULE16: Call uses word displacement, links into r15
// RULE17: Jump-and-link is indirect, links current PC
// RULE18: Save decrements window, adds across windows
// RULE19: Restore increments window, adds across windows
// RULE20: Save/restore check new window against mask
// RULE21: Delay slot runs before target or sequentially
// RULE22: Each non-trapping instruction moves next-PC into PC
// RULE23: Taken integer branch targets PC+4+displacement
// RULE24: Annul bit drops slot when untaken or always
// RULE25: Annulled slot changes nothing, never traps
// RULE26: Window pointer wraps modulo window count
`ifndef CTT_CFG_SVH
`define CTT_CFG_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define CTT_NWIN 8
`define CTT_WP_W 3
`define CTT_XLEN 32

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTT_RESET_PC 32'h0000_0000
`define CTT_RESET_NPC 32'h0000_0004
`define CTT_RESET_WP 3'h0

// ----------------------------------------
// Constants of the transfer logic
// ----------------------------------------
`define CTT_PC_STEP 32'h0000_0004
`define CTT_SW_TRAP_OFFSET 8'h80
`define CTT_TT_ILLEGAL 8'h02
`define CTT_TT_WIN_OVERFLOW 8'h05
`define CTT_TT_WIN_UNDERFLOW 8'h06
`define CTT_TT_RESET 8'h00
`define CTT_REG_CALL_LINK 5'h0F
`define CTT_REG_TRAP_PC 5'h11
`define CTT_REG_TRAP_NPC 5'h12
`define CTT_COND_ALWAYS 4'h8

// ----------------------------------------
// Trap base register fields
// ----------------------------------------
`define CTT_TBR_BASE_W 20
`define CTT_TBR_TT_W 8
`define CTT_TBR_ZERO 4'h0

`endif

// ---- rtl/ctt_pkg.sv ----
`include "ctt_cfg.svh"
package ctt_pkg;

   typedef enum logic [3:0] {
      OP_OTHER,
      OP_INT_BRANCH,
      OP_FLOAT_BRANCH,
      OP_COPROC_BRANCH,
      OP_CALL,
      OP_JUMP_LINK,
      OP_RETURN_TRAP,
      OP_COND_TRAP,
      OP_SAVE_WIN,
      OP_RESTORE_WIN
   } ctt_op_t;

   typedef enum logic [1:0] {
      CC_INT,
      CC_FLOAT,
      CC_COPROC
   } ctt_cc_class_t;

   typedef struct packed {
      logic valid;
      ctt_op_t op;
      logic [3:0] cond;
      logic annul;
      logic imm_sel;
      logic [12:0] signed_immediate;
      logic [29:0] disp;
      logic [4:0] rd;
   } ctt_instr_t;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } ctt_icc_t;

   typedef struct packed {
      logic we;
      logic [`CTT_WP_W-1:0] win;
      logic [4:0] idx;
      logic [`CTT_XLEN-1:0] data;
   } ctt_rf_wr_t;

endpackage

// ---- rtl/ctt_cond_eval.sv ----
`timescale 1ns/100ps
`include "ctt_cfg.svh"
module ctt_cond_eval
   import ctt_pkg::*;
(
   // Selection
   input wire ctt_cc_class_t cls,
   input wire logic [3:0] cond,
   // Condition sources
   input wire ctt_icc_t icc,
   input wire logic [1:0] fcc,
   input wire logic [1:0] ccc,
   // Result
   output logic cond_true
);

   logic low_int;
   logic [3:0] rel_mask;
   wire [1:0] rel_val = (cls == CC_FLOAT) ? fcc : ccc;
   wire low_rel = rel_mask[rel_val];
   wire low_true = (cls == CC_INT) ? low_int : low_rel;

   // Upper half of every table is the complement of the lower half
   assign cond_true = low_true ^ cond[3]; // RULE10 RULE13 RULE15

   always_comb begin
      unique case (cond[2:0])
         3'h0: low_int = 1'b0; // RULE11
         3'h1: low_int = icc.z; // RULE11
         3'h2: low_int = icc.z | (icc.n ^ icc.v); // RULE11
         3'h3: low_int = icc.n ^ icc.v;
         3'h4: low_int = icc.c | icc.z; // RULE11
         3'h5: low_int = icc.c;
         3'h6: low_int = icc.n;
         3'h7: low_int = icc.v;
      endcase
   end

   // Float values 0..3 are equal, less, greater, unordered; the
   // coprocessor value table happens to share the same masks
   always_comb begin
      unique case (cond[2:0])
         3'h0: rel_mask = 4'h0; // RULE12 RULE14
         3'h1: rel_mask = 4'hE;
         3'h2: rel_mask = 4'h6;
         3'h3: rel_mask = 4'hA;
         3'h4: rel_mask = 4'h2;
         3'h5: rel_mask = 4'hC;
         3'h6: rel_mask = 4'h4;
         3'h7: rel_mask = 4'h8;
      endcase
   end

endmodule

// ---- rtl/ctt_win_step.sv ----
`timescale 1ns/100ps
`include "ctt_cfg.svh"
module ctt_win_step
   import ctt_pkg::*;
(
   // Request
   input wire logic [`CTT_WP_W-1:0] wp,
   input wire logic step_up,
   input wire logic [`CTT_NWIN-1:0] invalid_window_mask,
   // Result
   output logic [`CTT_WP_W-1:0] new_wp,
   output logic new_invalid
);

   localparam logic [`CTT_WP_W-1:0] LAST_WIN = `CTT_WP_W'(`CTT_NWIN - 1);
   localparam logic [`CTT_WP_W-1:0] ONE_WIN = `CTT_WP_W'(1);

   wire [`CTT_WP_W-1:0] up_wp = (wp == LAST_WIN) ? '0 : wp + ONE_WIN; // RULE26
   wire [`CTT_WP_W-1:0] down_wp = (wp == '0) ? LAST_WIN : wp - ONE_WIN; // RULE26

   assign new_wp = step_up ? up_wp : down_wp;
   assign new_invalid = invalid_window_mask[new_wp]; // RULE20

endmodule

// ---- testbench/ctt_unit_checker.sv ----
`timescale 1ns/100ps
`include "ctt_cfg.svh"
module ctt_unit_checker
   import ctt_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction and operands
   input wire ctt_instr_t instr,
   input wire logic instr_ready,
   input wire logic [`CTT_XLEN-1:0] first_source,
   input wire logic [`CTT_XLEN-1:0] second_source,
   input wire logic [`CTT_NWIN-1:0] invalid_window_mask,
   // State
   input wire logic [`CTT_XLEN-1:0] pc,
   input wire logic [`CTT_XLEN-1:0] next_pc,
   input wire logic [`CTT_WP_W-1:0] window_pointer,
   input wire logic trap_enable_bit,
   input wire logic supervisor_bit,
   input wire logic prior_supervisor_bit,
   input wire logic [`CTT_XLEN-1:0] trap_base_reg,
   input wire logic error_mode,
   input wire logic annul_pending,
   // Writes and events
   input wire ctt_rf_wr_t wr_a,
   input wire ctt_rf_wr_t wr_b,
   input wire logic trap_taken,
   input wire logic illegal_trap,
   input wire logic window_overflow,
   input wire logic reset_trap
);
   // An annulled slot is excluded: it must not act at all
   wire logic acc = instr.valid && instr_ready && !annul_pending;
   wire logic [31:0] sum = first_source + (instr.imm_sel ?
      {{19{instr.signed_immediate[12]}}, instr.signed_immediate} : second_source);
   wire logic [6:0] tnum = sum[6:0];
   wire logic [2:0] wp_dn = window_pointer - 3'h1;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   trap_entry_state_a: assert property (trap_taken |-> !trap_enable_bit && supervisor_bit
      && prior_supervisor_bit == $past(supervisor_bit)) else $error("trap entry state wrong");
   trap_vector_a: assert property (trap_taken |-> pc == trap_base_reg
      && next_pc == trap_base_reg + 32'h4) else $error("trap vector wrong");
   trap_link_a: assert property (trap_taken |-> wr_a.we && wr_a.idx == 5'h11
      && wr_a.data == $past(pc) && wr_b.we && wr_b.idx == 5'h12 && wr_b.data == $past(next_pc)
      && wr_a.win == window_pointer) else $error("trap link writes wrong");
   sw_trap_type_a: assert property (acc && instr.op == OP_COND_TRAP ##1 trap_taken
      |-> trap_base_reg[11:4] == {1'b1, $past(tnum)}) else $error("software trap type wrong");
   ret_illegal_a: assert property (acc && instr.op == OP_RETURN_TRAP && trap_enable_bit
      |=> illegal_trap && trap_taken) else $error("return with traps on not refused");
   ret_fatal_a: assert property (acc && instr.op == OP_RETURN_TRAP && !trap_enable_bit
      && sum[1:0] != 2'b00 |=> reset_trap && error_mode) else $error("misaligned return missed");
   error_hold_a: assert property (error_mode |=> error_mode && !instr_ready
      && $stable(pc)) else $error("error mode not held");
   annul_quiet_a: assert property (instr.valid && instr_ready && annul_pending
      |=> !trap_taken && !wr_a.we && pc == $past(next_pc)) else $error("annulled slot acted");
   seq_step_a: assert property (acc && instr.op == OP_OTHER |=> pc == $past(next_pc)
      && next_pc == $past(next_pc) + 32'h4) else $error("sequential step wrong");
   save_wrap_a: assert property (acc && instr.op == OP_SAVE_WIN
      && !invalid_window_mask[wp_dn] |=> window_pointer == $past(wp_dn) && !window_overflow)
      else $error("save window step wrong");
   branch_always_a: assert property (acc && instr.op == OP_INT_BRANCH && instr.cond == 4'h8
      && instr.annul |=> annul_pending) else $error("branch always slot not annulled");
endmodule

bind ctt_unit ctt_unit_checker u_chk (.clk(clk), .rst_n(rst_n), .instr(instr),
   .instr_ready(instr_ready), .first_source(first_source), .second_source(second_source),
   .invalid_window_mask(invalid_window_mask), .pc(pc), .next_pc(next_pc),
   .window_pointer(window_pointer), .trap_enable_bit(trap_enable_bit),
   .supervisor_bit(supervisor_bit), .prior_supervisor_bit(prior_supervisor_bit),
   .trap_base_reg(trap_base_reg), .error_mode(error_mode), .annul_pending(annul_pending),
   .wr_a(wr_a), .wr_b(wr_b), .trap_taken(trap_taken), .illegal_trap(illegal_trap),
   .window_overflow(window_overflow), .reset_trap(reset_trap));

// ---- testbench/tb_ctt_unit.sv ----
`timescale 1ns/100ps
`include "ctt_cfg.svh"
module tb_ctt_unit import ctt_pkg::*;;
   logic clk, rst_n, instr_ready, trap_enable_bit, supervisor_bit, prior_supervisor_bit;
   logic error_mode, annul_pending, trap_taken, illegal_trap, window_overflow;
   logic window_underflow, reset_trap;
   ctt_instr_t instr;
   ctt_icc_t icc;
   ctt_rf_wr_t wr_a, wr_b;
   logic [31:0] first_source, second_source, pc, next_pc, trap_base_reg, m_pc, m_npc;
   logic [1:0] fcc, ccc;
   logic [7:0] invalid_window_mask, m_mask;
   logic [19:0] trap_base_addr;
   logic [2:0] window_pointer, m_wp;
   int err_count, compares;
   // Each row holds the fcc or ccc values that make a lower code true
   logic [3:0] lmask [8] = '{4'h0, 4'hE, 4'h6, 4'hA, 4'h2, 4'hC, 4'h4, 4'h8};

   ctt_unit dut (.clk(clk), .rst_n(rst_n), .instr(instr), .instr_ready(instr_ready),
      .first_source(first_source), .second_source(second_source), .icc(icc), .fcc(fcc),
      .ccc(ccc), .invalid_window_mask(invalid_window_mask), .trap_base_addr(trap_base_addr),
      .pc(pc), .next_pc(next_pc), .window_pointer(window_pointer),
      .trap_enable_bit(trap_enable_bit), .supervisor_bit(supervisor_bit),
      .prior_supervisor_bit(prior_supervisor_bit), .trap_base_reg(trap_base_reg),
      .error_mode(error_mode), .annul_pending(annul_pending), .wr_a(wr_a), .wr_b(wr_b),
      .trap_taken(trap_taken), .illegal_trap(illegal_trap), .window_overflow(window_overflow),
      .window_underflow(window_underflow), .reset_trap(reset_trap));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Held until the next call so exactly one edge takes it
   task automatic issue(input ctt_op_t o, input logic [3:0] cd, input logic [31:0] a = 0,
         input logic [31:0] b = 0, input logic an = 0, input logic isl = 0,
         input logic [12:0] im = 0, input logic [3:0] cc = 0);
      @(negedge clk);
      instr = '{1'b1, o, cd, an, isl, im, 30'h40, 5'h09};
      first_source = a;
      second_source = b;
      icc = cc;
      fcc = cc[1:0];
      ccc = cc[1:0];
      invalid_window_mask = m_mask;
      @(posedge clk);
      #1;
   endtask

   task automatic step(input logic [31:0] n);
      m_pc = m_npc;
      m_npc = n;
      chk("pc", m_pc, pc);
      chk("next_pc", m_npc, next_pc);
   endtask

   task automatic wchk(input logic [31:0] d);
      chk("window_pointer", m_wp, window_pointer);
      chk("window write", {1'b1, m_wp, 5'h09}, {wr_a.we, wr_a.win, wr_a.idx});
      chk("window write data", d, wr_a.data);
      step(m_npc + 32'h4);
   endtask

   task automatic trap_chk(input logic [7:0] tt);
      m_wp = m_wp - 3'h1;
      chk("trap_taken", 1, trap_taken);
      chk("trap_base_reg", {trap_base_addr, tt, 4'h0}, trap_base_reg);
      chk("window_pointer", m_wp, window_pointer);
      chk("trap flags", 2'b01, {trap_enable_bit, supervisor_bit});
      chk("pc save", {1'b1, 5'h11, m_wp}, {wr_a.we, wr_a.idx, wr_a.win});
      chk("pc save data", m_pc, wr_a.data);
      chk("next_pc save", {1'b1, 5'h12, m_wp}, {wr_b.we, wr_b.idx, wr_b.win});
      chk("next_pc save data", m_npc, wr_b.data);
      m_npc = {trap_base_addr, tt, 4'h0};
      step(m_npc + 32'h4);
   endtask

   function automatic logic cond_ok(input int k, input logic [3:0] c, input logic [3:0] v);
      logic [7:0] iv;
      iv = {v[1], v[3], v[0], v[0] | v[2], v[3] ^ v[1], v[2] | (v[3] ^ v[1]), v[2], 1'b0};
      return c[3] ^ (k == 0 ? iv[c[2:0]] : lmask[c[2:0]][v[1:0]]);
   endfunction

   initial begin
      #50000;
      err_count++;
      end_of_test;
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      instr = '0;
      first_source = '0;
      second_source = '0;
      icc = '0;
      fcc = '0;
      ccc = '0;
      invalid_window_mask = 8'h00;
      m_mask = 8'h00;
      trap_base_addr = 20'hABCDE;
      err_count = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      m_pc = 32'h0;
      m_npc = 32'h4;
      m_wp = 3'h0;
      chk("reset state", {32'h4, 3'h0, 4'b0110}, {next_pc, window_pointer, trap_enable_bit,
         supervisor_bit, instr_ready, error_mode});
      chk("pc", m_pc, pc);
      issue(OP_OTHER, 4'h0);
      step(m_npc + 32'h4);
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 16; c++) begin
            for (int v = 0; v < 16; v++) begin
               issue(ctt_op_t'(4'(k + 1)), 4'(c), 0, 0, 0, 0, 0, 4'(v));
               step(cond_ok(k, 4'(c), 4'(v)) ? m_pc + 32'h44 : m_npc + 32'h4);
            end
         end
      end
      issue(OP_INT_BRANCH, 4'h8, 0, 0, 1'b1);
      step(m_pc + 32'h44);
      chk("annul_pending", 1, annul_pending);
      issue(OP_COND_TRAP, 4'h8);
      chk("trap_taken", 0, trap_taken);
      step(m_npc + 32'h4);
      issue(OP_INT_BRANCH, 4'h0, 0, 0, 1'b1);
      step(m_npc + 32'h4);
      chk("annul_pending", 1, annul_pending);
      issue(OP_OTHER, 4'h0);
      step(m_npc + 32'h4);
      issue(OP_INT_BRANCH, 4'h9, 0, 0, 1'b1);
      step(m_pc + 32'h44);
      chk("annul_pending", 0, annul_pending);
      issue(OP_OTHER, 4'h0);
      step(m_npc + 32'h4);
      issue(OP_CALL, 4'h0);
      chk("call link", {1'b1, 3'h0, 5'h0F}, {wr_a.we, wr_a.win, wr_a.idx});
      chk("call link data", m_pc, wr_a.data);
      step(m_pc + 32'h100);
      issue(OP_JUMP_LINK, 4'h0, 32'h1000, 0, 0, 1'b1, 13'h1FF8);
      chk("jump link", {1'b1, 3'h0, 5'h09}, {wr_a.we, wr_a.win, wr_a.idx});
      chk("jump link data", m_pc, wr_a.data);
      step(32'hFF8);
      issue(OP_SAVE_WIN, 4'h0, 32'h5, 32'h6);
      m_wp = m_wp - 3'h1;
      wchk(32'hB);
      issue(OP_RESTORE_WIN, 4'h0, 32'h7, 32'h1);
      m_wp = m_wp + 3'h1;
      wchk(32'h8);
      m_mask = 8'h80;
      issue(OP_SAVE_WIN, 4'h0);
      chk("window_overflow", 1, window_overflow);
      trap_chk(8'h05);
      m_mask = 8'h01;
      issue(OP_RESTORE_WIN, 4'h0);
      chk("window_underflow", 1, window_underflow);
      trap_chk(8'h06);
      m_mask = 8'h00;
      issue(OP_COND_TRAP, 4'h0, 32'h1, 32'h1);
      chk("trap_taken", {1'b0, m_wp}, {trap_taken, window_pointer});
      step(m_npc + 32'h4);
      issue(OP_COND_TRAP, 4'h8, 32'hFF, 0, 0, 1'b1, 13'h1FFE);
      trap_chk(8'hFD);
      issue(OP_COND_TRAP, 4'h8, 32'h10, 32'h3);
      trap_chk(8'h93);
      issue(OP_RETURN_TRAP, 4'h0, 32'h2000, 32'h4);
      m_wp = m_wp + 3'h1;
      chk("return state", {m_wp, 2'b11}, {window_pointer, trap_enable_bit, supervisor_bit});
      step(32'h2004);
      issue(OP_RETURN_TRAP, 4'h0, 32'h2000, 32'h4);
      chk("illegal_trap", 1, illegal_trap);
      trap_chk(8'h02);
      issue(OP_RETURN_TRAP, 4'h0, 32'h2002, 32'h0);
      chk("reset trap", 3'b110, {reset_trap, error_mode, instr_ready});
      chk("pc", m_pc, pc);
      issue(OP_OTHER, 4'h0);
      chk("pc", m_pc, pc);
      @(negedge clk);
      instr.valid = 1'b0;
      end_of_test;
   end
endmodule
